// [hdl/fvi_map.vh]
// register map, field layout and reset patterns of the fast vector readout block
// assumes a 32-bit AXI4-Lite slave with 12-bit byte addresses
`ifndef FVI_MAP_VH
`define FVI_MAP_VH
`define FVI_ADDR_W 12
`define FVI_ACK_LOW 12'h060
`define FVI_ACK_HIGH 12'h064
`define FVI_STD_INFO 12'h06C
`define FVI_FAST_VEC 12'h070
`define FVI_FAST_INFO 12'h074
`define FVI_FSEL_LOW 12'h078
`define FVI_FSEL_HIGH 12'h07C
`define FVI_VEC_BASE 12'h080
`define FVI_VEC_END 12'h17C
`define FVI_VEC_BASE_IDX 7'h20
`define FVI_IRQ_STATUS 12'h1A0
`define FVI_IRQ_MASK 12'h1A4
`define FVI_IDLE_PATTERN 32'h0FFFFFFF
`define FVI_VEC_RESET 32'h00000000
`define FVI_NUM_LSB 0
`define FVI_NUM_MSB 5
`define FVI_LVL_LSB 8
`define FVI_LVL_MSB 10
`define FVI_ROT_BIT 24
`define FVI_EV_ASSERT 0
`define FVI_EV_ACK 1
`define FVI_EV_W 2
`define FVI_RESP_OKAY 2'h0
`define FVI_RESP_SLVERR 2'h2
`endif

// [hdl/fvi_fast_vector_info.v]
// fast-request readout of a 64-source prioritizing interrupt controller, AXI4-Lite slave
// assumes request lines and per-source levels are synchronous to aclk and held until acknowledged
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`include "fvi_map.vh"
module fvi_fast_vector_info (
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [63:0] src_request,
   input wire [191:0] src_level,
   output reg fast_interrupt_request,
   output reg irq
);

   // configuration, asserted-source tracking and write holding registers
   reg [31:0] vec_mem [0:63];
   reg [31:0] fast_select_low_reg;
   reg [31:0] fast_select_high_reg;
   reg rot_disable_reg;
   reg [63:0] rr_mask_reg;
   reg active_reg;
   reg [5:0] num_reg;
   reg [2:0] lvl_reg;
   reg [1:0] status_reg;
   reg [1:0] mask_reg;
   reg [11:0] awaddr_reg;
   reg aw_held_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg w_held_reg;

   // pending fast requests and address decode of the held write and the live read
   // masked sources stay out of the search, so a masked source cannot win its level again
   wire [63:0] fast_sel = {fast_select_high_reg, fast_select_low_reg};
   wire [63:0] fast_pend = src_request & fast_sel & ~rr_mask_reg;
   wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   wire [6:0] wvec_off = awaddr_reg[8:2] - `FVI_VEC_BASE_IDX;
   wire [6:0] rvec_off = s_axi_araddr[8:2] - `FVI_VEC_BASE_IDX;
   wire w_in_vec = (awaddr_reg >= `FVI_VEC_BASE) && (awaddr_reg <= `FVI_VEC_END);
   wire r_in_vec = (s_axi_araddr >= `FVI_VEC_BASE) && (s_axi_araddr <= `FVI_VEC_END);

   // merge write data under byte enables
   function [31:0] merge_bytes;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      integer b;
      begin
         merge_bytes = old_val;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
            end
         end
      end
   endfunction

   // acknowledge pulse: one bit per source written with a one, level is not consulted
   reg [63:0] ack_vec;
   always @* begin
      ack_vec = 64'h0000000000000000;
      if (do_write && awaddr_reg == `FVI_ACK_LOW) begin
         ack_vec[31:0] = merge_bytes(32'h00000000, wdata_reg, wstrb_reg);
      end
      if (do_write && awaddr_reg == `FVI_ACK_HIGH) begin
         ack_vec[63:32] = merge_bytes(32'h00000000, wdata_reg, wstrb_reg);
      end
   end

   // winner search: highest level, ties to the lowest source number
   // a flat 64-way scan costs more logic than a tree but keeps the answer in one cycle
   reg found;
   reg [5:0] best_idx;
   reg [2:0] best_lvl;
   reg [7:0] level_open;
   integer i;
   always @* begin
      found = 1'b0;
      best_idx = 6'h00;
      best_lvl = 3'h0;
      level_open = 8'h00;
      for (i = 63; i >= 0; i = i - 1) begin
         if (fast_pend[i]) begin
            level_open[src_level[i*3 +: 3]] = 1'b1;
            if (!found || src_level[i*3 +: 3] >= best_lvl) begin
               found = 1'b1;
               best_idx = i[5:0];
               best_lvl = src_level[i*3 +: 3];
            end
         end
      end
   end

   // does anything else wait at the level of the source being acknowledged
   reg others_wait;
   integer k;
   always @* begin
      others_wait = 1'b0;
      for (k = 0; k < 64; k = k + 1) begin
         if (fast_pend[k] && k[5:0] != num_reg && src_level[k*3 +: 3] == lvl_reg) begin
            others_wait = 1'b1;
         end
      end
   end

   // an acknowledge ends the asserted source at the write edge; that source may not win again
   // on the same edge, so a waiting peer is latched once the acknowledged source is masked
   wire active_end = active_reg & (ack_vec[num_reg] | ~src_request[num_reg] | ~fast_sel[num_reg]);
   wire active_start = (~active_reg | active_end) & found & ~ack_vec[best_idx];
   wire ack_event = active_reg & ack_vec[num_reg];

   // round-robin mask: a level's masks drop once no unmasked request remains there
   reg [63:0] rr_mask_next;
   integer m;
   always @* begin
      rr_mask_next = rr_mask_reg;
      for (m = 0; m < 64; m = m + 1) begin
         if (!level_open[src_level[m*3 +: 3]]) begin
            rr_mask_next[m] = 1'b0;
         end
      end
      if (rot_disable_reg) begin
         rr_mask_next = 64'h0000000000000000;
      end else if (ack_event && others_wait) begin
         rr_mask_next[num_reg] = 1'b1;
      end
   end

   // asserted fast source tracking and round-robin state
   always @(posedge aclk) begin
      if (!aresetn) begin
         active_reg <= 1'b0;
         num_reg <= 6'h00;
         lvl_reg <= 3'h0;
         rr_mask_reg <= 64'h0000000000000000;
         fast_interrupt_request <= 1'b0;
      end else begin
         rr_mask_reg <= rr_mask_next;
         if (active_start) begin
            active_reg <= 1'b1;
            num_reg <= best_idx;
            lvl_reg <= best_lvl;
         end else if (active_end) begin
            active_reg <= 1'b0;
         end
         fast_interrupt_request <= active_start | (active_reg & ~active_end);
      end
   end

   // configuration writes; readout registers ignore writes
   integer v;
   always @(posedge aclk) begin
      if (!aresetn) begin
         for (v = 0; v < 64; v = v + 1) begin
            vec_mem[v] <= `FVI_VEC_RESET;
         end
         fast_select_low_reg <= 32'h00000000;
         fast_select_high_reg <= 32'h00000000;
         rot_disable_reg <= 1'b0;
         mask_reg <= 2'h0;
      end else if (do_write) begin
         if (w_in_vec) begin
            vec_mem[wvec_off[5:0]] <= merge_bytes(vec_mem[wvec_off[5:0]], wdata_reg, wstrb_reg);
         end
         case (awaddr_reg)
            `FVI_FSEL_LOW: begin
               fast_select_low_reg <= merge_bytes(fast_select_low_reg, wdata_reg, wstrb_reg);
            end
            `FVI_FSEL_HIGH: begin
               fast_select_high_reg <= merge_bytes(fast_select_high_reg, wdata_reg, wstrb_reg);
            end
            `FVI_STD_INFO: begin
               if (wstrb_reg[3]) begin
                  rot_disable_reg <= wdata_reg[`FVI_ROT_BIT];
               end
            end
            `FVI_IRQ_MASK: begin
               if (wstrb_reg[0]) begin
                  mask_reg <= wdata_reg[`FVI_EV_W-1:0];
               end
            end
            default: begin
               // fast vector and fast info take no write
            end
         endcase
      end
   end

   // sticky event status, write one to clear; a new event beats the clear
   wire [1:0] ev_set = {ack_event, active_start & ~active_reg};
   wire [1:0] ev_clr = (do_write && awaddr_reg == `FVI_IRQ_STATUS && wstrb_reg[0]) ?
                       wdata_reg[`FVI_EV_W-1:0] : 2'h0;
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= 2'h0;
         irq <= 1'b0;
      end else begin
         status_reg <= (status_reg & ~ev_clr) | ev_set;
         irq <= |(((status_reg & ~ev_clr) | ev_set) & mask_reg);
      end
   end

   // read mux; idle fast vector and fast info readouts show the idle pattern so software sees no fast source
   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      if (r_in_vec) begin
         rd_val = vec_mem[rvec_off[5:0]];
      end else begin
         case (s_axi_araddr)
            `FVI_FAST_VEC: begin
               rd_val = active_reg ? vec_mem[num_reg] : `FVI_IDLE_PATTERN;
            end
            `FVI_FAST_INFO: begin
               if (active_reg) begin
                  rd_val[`FVI_NUM_MSB:`FVI_NUM_LSB] = num_reg;
                  rd_val[`FVI_LVL_MSB:`FVI_LVL_LSB] = lvl_reg;
                  rd_val[`FVI_ROT_BIT] = rot_disable_reg;
               end else begin
                  rd_val = `FVI_IDLE_PATTERN;
               end
            end
            `FVI_STD_INFO: begin
               rd_val[`FVI_ROT_BIT] = active_reg ? rot_disable_reg : 1'b1;
            end
            `FVI_FSEL_LOW: begin
               rd_val = fast_select_low_reg;
            end
            `FVI_FSEL_HIGH: begin
               rd_val = fast_select_high_reg;
            end
            `FVI_ACK_LOW, `FVI_ACK_HIGH: begin
               rd_val = 32'h00000000; // write-only, reads zero
            end
            `FVI_IRQ_STATUS: begin
               rd_val[`FVI_EV_W-1:0] = status_reg;
            end
            `FVI_IRQ_MASK: begin
               rd_val[`FVI_EV_W-1:0] = mask_reg;
            end
            default: begin
               rd_ok = 1'b0;
            end
         endcase
      end
   end

   // write decode validity, checked once both halves are held
   reg wr_ok;
   always @* begin
      case (awaddr_reg)
         `FVI_ACK_LOW, `FVI_ACK_HIGH, `FVI_STD_INFO, `FVI_FAST_VEC, `FVI_FAST_INFO,
         `FVI_FSEL_LOW, `FVI_FSEL_HIGH, `FVI_IRQ_STATUS, `FVI_IRQ_MASK: begin
            wr_ok = 1'b1;
         end
         default: begin
            wr_ok = w_in_vec;
         end
      endcase
   end

   // write channels: address and data taken in either order, response after both
   // ready is a registered pulse, so each channel takes at most one beat per request
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 12'h000;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FVI_RESP_OKAY;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
         end else if (!aw_held_reg && !s_axi_bvalid && s_axi_awvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (!w_held_reg && !s_axi_bvalid && s_axi_wvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `FVI_RESP_OKAY : `FVI_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one read at a time, data sampled at the address handshake
   // limitation: rdata is a snapshot, a source change after the handshake is not shown
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `FVI_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? `FVI_RESP_OKAY : `FVI_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid && s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // fvi_fast_vector_info

// [tb/fvi_source_model.sv]
// interrupt sources on the far side of the fast readout block
// assumes the bench pulses raise_req and drop_req for one aclk cycle
`timescale 1ns/100ps
module fvi_source_model (
   input wire aclk,
   input wire aresetn,
   input wire [63:0] raise_req,
   input wire [63:0] drop_req,
   output reg [63:0] src_request
);
   // a source keeps requesting until its handler drops it; drop wins over raise
   always @(posedge aclk) begin
      if (!aresetn)
         src_request <= 64'h0;
      else
         src_request <= (src_request | raise_req) & ~drop_req;
   end
endmodule // fvi_source_model

// [tb/fvi_fast_vector_info_asserts.sv]
// port-level checks of the fast readout block
// assumes one aclk domain with a synchronous active-low reset
`timescale 1ns/100ps
module fvi_fast_vector_info_chk (
   input wire aclk,
   input wire aresetn,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [63:0] src_request,
   input wire fast_interrupt_request
);
   reg [11:0] rd_addr_reg;
   reg rd_fast_reg;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // read data is taken at the handshake edge, so remember address and state there
   always @(posedge aclk) begin
      if (!aresetn) begin
         rd_addr_reg <= 12'h000;
         rd_fast_reg <= 1'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_reg <= s_axi_araddr;
         rd_fast_reg <= fast_interrupt_request;
      end
   end
   b_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   r_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before rready");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   r_follow_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   fast_needs_req_a: assert property (!(|src_request) |=> !fast_interrupt_request)
      else $error("fast request without any source");
   idle_vector_a: assert property ($rose(s_axi_rvalid) && rd_addr_reg == 12'h070 && !rd_fast_reg |->
      s_axi_rdata == 32'h0FFFFFFF) else $error("idle vector readout wrong");
   idle_info_a: assert property ($rose(s_axi_rvalid) && rd_addr_reg == 12'h074 && !rd_fast_reg |->
      s_axi_rdata == 32'h0FFFFFFF) else $error("idle info readout wrong");
   rot_idle_a: assert property ($rose(s_axi_rvalid) && rd_addr_reg == 12'h06C && !rd_fast_reg |->
      s_axi_rdata[24]) else $error("ordering bit not one while idle");
endmodule // fvi_fast_vector_info_chk
bind fvi_fast_vector_info fvi_fast_vector_info_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .src_request(src_request), .fast_interrupt_request(fast_interrupt_request));

// [tb/test_fast_irq_vector_info.sv]
// self-checking bench of the fast readout block over AXI4-Lite
// assumes the source model holds requests until the bench drops them
`timescale 1ns/100ps
module test_fast_irq_vector_info;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, rdat, v;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [191:0] src_level = 0;
   logic [63:0] raise_req = 0, drop_req = 0;
   logic [1:0] bres, rres;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fast_interrupt_request, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [63:0] src_request;
   int fails = 0, total_checks = 0, cycles = 0, i, s;
   int srcs [4] = '{0, 37, 63, 31};
   logic [2:0] lvls [4] = '{3'h1, 3'h7, 3'h3, 3'h0};
   fvi_fast_vector_info u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .src_request(src_request), .src_level(src_level),
      .fast_interrupt_request(fast_interrupt_request), .irq(irq));
   fvi_source_model u_src (.aclk(aclk), .aresetn(aresetn), .raise_req(raise_req), .drop_req(drop_req),
      .src_request(src_request));
   always #5 aclk = ~aclk;
   // a hang anywhere ends the run as a failure
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         end_of_test;
      end
   end
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, fails);
         if (fails == 0 && total_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         total_checks++;
         if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // address and data offered together, each released at its own handshake
   task wr(input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         end while (s_axi_bvalid !== 1'h1);
         bres = s_axi_bresp;
         s_axi_bready <= 1'h0;
      end
   endtask
   task rd(input logic [11:0] a);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         end while (s_axi_rvalid !== 1'h1);
         rdat = s_axi_rdata;
         rres = s_axi_rresp;
         s_axi_rready <= 1'h0;
      end
   endtask
   task src(input logic [63:0] up, input logic [63:0] dn);
      begin
         raise_req <= up;
         drop_req <= dn;
         @(posedge aclk);
         raise_req <= 64'h0;
         drop_req <= 64'h0;
      end
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rd(12'h070);
      chk("vector idle", rdat, 32'h0FFFFFFF);
      rd(12'h074);
      chk("info idle", rdat, 32'h0FFFFFFF);
      rd(12'h06C);
      chk("ordering idle", rdat, 32'h01000000);
      rd(12'h0FC);
      chk("vector reset", rdat, 32'h0);
      rd(12'h07C);
      chk("select reset", rdat, 32'h0);
      wr(12'h190, 32'h1);
      chk("unmapped write", {30'h0, bres}, 32'h2);
      rd(12'h190);
      chk("unmapped read", {30'h0, rres}, 32'h2);
      $display("reset test done");
      // each row: source, level; the vector is derived from the source number
      for (i = 0; i < 4; i++) begin
         s = srcs[i];
         v = 32'hC0A00000 + s;
         src_level[3 * s +: 3] <= lvls[i];
         wr(12'(128 + 4 * s), v);
         wr(s < 32 ? 12'h078 : 12'h07C, 32'h1 << s[4:0]);
         wr(12'h1A4, {31'h0, ~i[0]});
         src(64'h1 << s, 64'h0);
         wr(12'h070, ~v);
         wr(12'h074, 32'h0);
         rd(12'h070);
         chk("vector", rdat, v);
         rd(12'h074);
         chk("info", rdat, {21'h0, lvls[i], 2'h0, s[5:0]});
         chk("irq set", {31'h0, irq}, {31'h0, ~i[0]});
         chk("fast request", {31'h0, fast_interrupt_request}, 32'h1);
         rd(12'h06C);
         chk("ordering active", rdat, 32'h0);
         wr(s < 32 ? 12'h060 : 12'h064, 32'h1 << s[4:0]);
         rd(12'h1A0);
         chk("events", rdat, 32'h3);
         src(64'h0, 64'h1 << s);
         rd(12'h070);
         chk("vector after", rdat, 32'h0FFFFFFF);
         chk("fast dropped", {31'h0, fast_interrupt_request}, 32'h0);
         wr(12'h1A0, 32'h3);
         wr(s < 32 ? 12'h078 : 12'h07C, 32'h0);
         chk("irq clear", {31'h0, irq}, 32'h0);
      end
      $display("row test done");
      // sources 3 and 7 tie at level 5
      src_level[11:9] <= 3'h5;
      src_level[23:21] <= 3'h5;
      wr(12'h078, 32'h88);
      src(64'h88, 64'h0);
      rd(12'h074);
      chk("tie order", rdat, 32'h503);
      wr(12'h060, 32'h8);
      rd(12'h074);
      chk("rotation", rdat, 32'h507);
      src(64'h0, 64'h88);
      wr(12'h06C, 32'h01000000);
      src(64'h88, 64'h0);
      rd(12'h074);
      chk("mirror", rdat, 32'h01000503);
      wr(12'h060, 32'h8);
      rd(12'h074);
      chk("fixed order", rdat, 32'h01000503);
      rd(12'h06C);
      chk("ordering held", rdat, 32'h01000000);
      src(64'h200, 64'h88);
      rd(12'h070);
      chk("standard source", rdat, 32'h0FFFFFFF);
      $display("ordering test done");
      // reset in mid-run with rotation disabled and vectors written
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(12'h114);
      chk("vector cleared", rdat, 32'h0);
      rd(12'h074);
      chk("info reset", rdat, 32'h0FFFFFFF);
      wr(12'h078, 32'h8);
      src(64'h8, 64'h0);
      rd(12'h074);
      chk("rotation reset", rdat, 32'h503);
      chk("fast after reset", {31'h0, fast_interrupt_request}, 32'h1);
      $display("mid-run reset test done");
      end_of_test;
   end
endmodule // test_fast_irq_vector_info
